// >>> hdl/tw_defines.vh
/*
 * Register offsets, field positions and reset values of the two-wire
 * master/slave port. Assumes an APB slave with 8-bit byte addresses.
 */
`ifndef TW_DEFINES_VH
`define TW_DEFINES_VH
`define TW_OFF_RXBUF 8'h00
`define TW_OFF_TXB 8'h04
`define TW_OFF_BAUD 8'h08
`define TW_OFF_CTL 8'h0C
`define TW_OFF_STAT 8'h10
`define TW_OFF_ADDR 8'h14
`define TW_OFF_IRQ 8'h18
`define TW_OFF_MASK 8'h1C
`define TW_C_EN 15
`define TW_C_CLKREL 12
`define TW_C_AWIDTH 10
`define TW_C_RXSTR 6
`define TW_C_ACKVAL 5
`define TW_C_ACKGO 4
`define TW_C_RXGO 3
`define TW_C_STOPGO 2
`define TW_C_RSTGO 1
`define TW_C_STARTGO 0
`define TW_S_ACKIN 15
`define TW_S_MTXBUSY 14
`define TW_S_COLL 10
`define TW_S_TENMATCH 8
`define TW_S_WRCOLL 7
`define TW_S_OVER 6
`define TW_S_DATA 5
`define TW_S_STOPSEEN 4
`define TW_S_STARTSEEN 3
`define TW_S_DIR 2
`define TW_S_RXFULL 1
`define TW_S_TXFULL 0
`define TW_S_RO_W 6
`define TW_I_SLV 0
`define TW_I_MST 1
`define TW_I_COLL 2
`define TW_CTL_RST 16'h1000
`define TW_STAT_RST 16'h0000
`define TW_BAUD_RST 9'h000
`define TW_ADDR_RST 10'h000
`define TW_TEN_PREFIX 5'h1E
`endif

// >>> hdl/tw_port.v
/*
 * Two-wire serial port, master and slave, 7/10-bit addressing, with
 * APB register access and a level interrupt.
 * Assumes scl_in/sda_in are synchronous to pclk and the bus wires are
 * resolved outside from the active-low output enables.
 */
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "tw_defines.vh"
module tw_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_n,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  output reg irq
);
  localparam M_IDLE = 4'd0;
  localparam M_S1 = 4'd1;
  localparam M_S2 = 4'd2;
  localparam M_WAIT = 4'd3;
  localparam M_LOW = 4'd4;
  localparam M_HIGH = 4'd5;
  localparam M_P1 = 4'd6;
  localparam M_P2 = 4'd7;
  localparam M_R1 = 4'd8;
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ADDR2 = 3'd2;
  localparam S_ACK = 3'd3;
  localparam S_RX = 3'd4;
  localparam S_TXW = 3'd5;
  localparam S_TX = 3'd6;
  localparam S_TXA = 3'd7;

  reg [15:0] ctl_r;
  reg [15:0] st_r;
  reg [7:0] rxb_r;
  reg [7:0] txb_r;
  reg [8:0] baud_r;
  reg [9:0] adr_r;
  reg [2:0] irqst_r;
  reg [2:0] mask_r;
  reg scl_q;
  reg sda_q;
  reg busy_r;
  reg [3:0] mst_r;
  reg [8:0] cnt_r;
  reg [3:0] mbit_r;
  reg [8:0] msh_r;
  reg mrx_r;
  reg mtx_r;
  reg msda_r;
  reg mscl_r;
  reg mown_r;
  reg [2:0] sst_r;
  reg [2:0] snx_r;
  reg [3:0] sbit_r;
  reg [7:0] rsr_r;
  reg [7:0] tsh_r;
  reg ssda_r;
  reg prior_r;
  reg [31:0] rdata;
  reg rerr;

  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_det = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_det = scl_in & scl_q & ~sda_q & sda_in;
  wire tick = (cnt_r == 9'h000);
  wire sl_ok = ~mown_r & (mst_r == M_IDLE);
  wire shold = ((sst_r == S_TXW) | (sst_r == S_RX)) & ~ctl_r[`TW_C_CLKREL];
  wire lose = ~msda_r & ~sda_in & ~mrx_r & ~(mtx_r & (mbit_r == 4'd1));

  // register read mux
  always @* begin
    rdata = 32'h0000_0000;
    rerr = 1'b0;
    case (paddr)
      `TW_OFF_RXBUF: rdata = {24'h00_0000, rxb_r};
      `TW_OFF_TXB: rdata = {24'h00_0000, txb_r};
      `TW_OFF_BAUD: rdata = {23'h00_0000, baud_r};
      `TW_OFF_CTL: rdata = {16'h0000, ctl_r};
      `TW_OFF_STAT: rdata = {16'h0000, st_r};
      `TW_OFF_ADDR: rdata = {22'h00_0000, adr_r};
      `TW_OFF_IRQ: rdata = {29'h0000_0000, irqst_r};
      `TW_OFF_MASK: rdata = {29'h0000_0000, mask_r};
      default: rerr = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      irq <= 1'b0;
      ctl_r <= `TW_CTL_RST;
      st_r <= `TW_STAT_RST;
      rxb_r <= 8'h00;
      txb_r <= 8'h00;
      baud_r <= `TW_BAUD_RST;
      adr_r <= `TW_ADDR_RST;
      irqst_r <= 3'h0;
      mask_r <= 3'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_r <= 1'b0;
      mst_r <= M_IDLE;
      cnt_r <= 9'h000;
      mbit_r <= 4'h0;
      msh_r <= 9'h1FF;
      mrx_r <= 1'b0;
      mtx_r <= 1'b0;
      msda_r <= 1'b0;
      mscl_r <= 1'b0;
      mown_r <= 1'b0;
      sst_r <= S_IDLE;
      snx_r <= S_IDLE;
      sbit_r <= 4'h0;
      rsr_r <= 8'h00;
      tsh_r <= 8'h00;
      ssda_r <= 1'b0;
      prior_r <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= rdata;
        pslverr <= rerr;
      end
      irq <= |(irqst_r & mask_r);
      // open-drain pins: only ever pull low
      scl_oe_n <= ~(mscl_r | shold);
      sda_oe_n <= ~(msda_r | ssda_r);
      // software writes
      if (wr) begin
        case (paddr)
          `TW_OFF_TXB: txb_r <= pwdata[7:0];
          `TW_OFF_BAUD: baud_r <= pwdata[8:0];
          `TW_OFF_CTL: ctl_r <= pwdata[15:0];
          `TW_OFF_STAT:
            st_r[15:`TW_S_RO_W] <= pwdata[15:`TW_S_RO_W];
          `TW_OFF_ADDR: adr_r <= pwdata[9:0];
          `TW_OFF_MASK: mask_r <= pwdata[2:0];
          default: ;
        endcase
      end
      if (rd && paddr == `TW_OFF_RXBUF)
        st_r[`TW_S_RXFULL] <= 1'b0;
      if (rd && paddr == `TW_OFF_IRQ)
        irqst_r <= 3'h0;
      // bus condition tracking
      if (start_det) begin
        busy_r <= 1'b1;
        st_r[`TW_S_STARTSEEN] <= 1'b1;
        st_r[`TW_S_STOPSEEN] <= 1'b0;
      end
      if (stop_det) begin
        busy_r <= 1'b0;
        st_r[`TW_S_STOPSEEN] <= 1'b1;
        st_r[`TW_S_STARTSEEN] <= 1'b0;
      end
      // baud counter, stalls while scl is stretched high phase
      if (mst_r == M_IDLE || mst_r == M_WAIT || tick)
        cnt_r <= baud_r;
      else if (mst_r != M_HIGH || scl_in)
        cnt_r <= cnt_r - 9'd1;
      // master sequencer
      case (mst_r)
        M_IDLE: begin
          if (ctl_r[`TW_C_STARTGO]) begin
            if (busy_r) begin
              st_r[`TW_S_COLL] <= 1'b1;
              irqst_r[`TW_I_COLL] <= 1'b1;
              ctl_r[`TW_C_STARTGO] <= 1'b0;
            end else begin
              mst_r <= M_S1;
            end
          end
        end
        M_S1: begin
          msda_r <= 1'b0;
          mscl_r <= 1'b0;
          if (tick) begin
            msda_r <= 1'b1;
            mst_r <= M_S2;
          end
        end
        M_S2: if (tick) begin
          mscl_r <= 1'b1;
          mown_r <= 1'b1;
          ctl_r[`TW_C_STARTGO] <= 1'b0;
          ctl_r[`TW_C_RSTGO] <= 1'b0;
          irqst_r[`TW_I_MST] <= 1'b1;
          mst_r <= M_WAIT;
        end
        M_WAIT: begin
          if (ctl_r[`TW_C_STOPGO]) begin
            msda_r <= 1'b1;
            mst_r <= M_P1;
          end else if (ctl_r[`TW_C_RSTGO]) begin
            msda_r <= 1'b0;
            mst_r <= M_R1;
          end else if (ctl_r[`TW_C_ACKGO]) begin
            msh_r <= {ctl_r[`TW_C_ACKVAL], 8'hFF};
            mbit_r <= 4'd1;
            mrx_r <= 1'b0;
            mtx_r <= 1'b0;
            mst_r <= M_LOW;
          end else if (ctl_r[`TW_C_RXGO]) begin
            msh_r <= 9'h1FF;
            mbit_r <= 4'd8;
            mrx_r <= 1'b1;
            mtx_r <= 1'b0;
            mst_r <= M_LOW;
          end else if (st_r[`TW_S_TXFULL]) begin
            msh_r <= {txb_r, 1'b1};
            st_r[`TW_S_TXFULL] <= 1'b0;
            st_r[`TW_S_MTXBUSY] <= 1'b1;
            mbit_r <= 4'd9;
            mrx_r <= 1'b0;
            mtx_r <= 1'b1;
            mst_r <= M_LOW;
          end
        end
        M_LOW: begin
          mscl_r <= 1'b1;
          msda_r <= ~msh_r[8];
          if (tick) begin
            mscl_r <= 1'b0;
            mst_r <= M_HIGH;
          end
        end
        M_HIGH: if (tick) begin
          if (lose) begin
            st_r[`TW_S_COLL] <= 1'b1;
            st_r[`TW_S_MTXBUSY] <= 1'b0;
            irqst_r[`TW_I_COLL] <= 1'b1;
            msda_r <= 1'b0;
            mscl_r <= 1'b0;
            mown_r <= 1'b0;
            mst_r <= M_IDLE;
          end else begin
            msh_r <= {msh_r[7:0], 1'b1};
            if (mrx_r)
              rsr_r <= {rsr_r[6:0], sda_in};
            mscl_r <= 1'b1;
            mbit_r <= mbit_r - 4'd1;
            mst_r <= M_LOW;
            if (mbit_r == 4'd1) begin
              mst_r <= M_WAIT;
              irqst_r[`TW_I_MST] <= 1'b1;
              ctl_r[`TW_C_ACKGO] <= 1'b0;
              if (mtx_r) begin
                st_r[`TW_S_ACKIN] <= sda_in;
                st_r[`TW_S_MTXBUSY] <= 1'b0;
              end
              if (mrx_r) begin
                ctl_r[`TW_C_RXGO] <= 1'b0;
                if (st_r[`TW_S_RXFULL]) begin
                  st_r[`TW_S_OVER] <= 1'b1;
                end else begin
                  rxb_r <= {rsr_r[6:0], sda_in};
                  st_r[`TW_S_RXFULL] <= 1'b1;
                end
              end
            end
          end
        end
        M_P1: if (tick) begin
          mscl_r <= 1'b0;
          mst_r <= M_P2;
        end
        M_P2: if (tick) begin
          msda_r <= 1'b0;
          mown_r <= 1'b0;
          ctl_r[`TW_C_STOPGO] <= 1'b0;
          irqst_r[`TW_I_MST] <= 1'b1;
          mst_r <= M_IDLE;
        end
        M_R1: if (tick) begin
          mscl_r <= 1'b0;
          mst_r <= M_S1;
        end
        default: mst_r <= M_IDLE;
      endcase
      // slave sequencer
      if (stop_det) begin
        sst_r <= S_IDLE;
        prior_r <= 1'b0;
        ssda_r <= 1'b0;
      end else if (start_det && sl_ok) begin
        sst_r <= S_ADDR;
        sbit_r <= 4'h0;
        ssda_r <= 1'b0;
      end else begin
        case (sst_r)
          S_ADDR, S_ADDR2, S_RX: begin
            if (scl_rise) begin
              rsr_r <= {rsr_r[6:0], sda_in};
              sbit_r <= sbit_r + 4'd1;
            end
            if (scl_fall && sbit_r == 4'd8) begin
              sbit_r <= 4'h0;
              sst_r <= S_IDLE;
              if (sst_r == S_RX) begin
                sst_r <= S_ACK;
                snx_r <= S_RX;
                st_r[`TW_S_DATA] <= 1'b1;
                if (st_r[`TW_S_RXFULL]) begin
                  st_r[`TW_S_OVER] <= 1'b1;
                end else begin
                  rxb_r <= rsr_r;
                  st_r[`TW_S_RXFULL] <= 1'b1;
                  ssda_r <= 1'b1;
                end
              end else if (sst_r == S_ADDR2) begin
                st_r[`TW_S_TENMATCH] <= 1'b0;
                if (rsr_r == adr_r[7:0]) begin
                  st_r[`TW_S_TENMATCH] <= 1'b1;
                  prior_r <= 1'b1;
                  snx_r <= S_RX;
                  sst_r <= S_ACK;
                  ssda_r <= 1'b1;
                end
              end else if (!ctl_r[`TW_C_AWIDTH]) begin
                if (rsr_r[7:1] == adr_r[6:0]) begin
                  st_r[`TW_S_DIR] <= rsr_r[0];
                  st_r[`TW_S_DATA] <= 1'b0;
                  snx_r <= rsr_r[0] ? S_TXW : S_RX;
                  sst_r <= S_ACK;
                  ssda_r <= 1'b1;
                end
              end else begin
                st_r[`TW_S_TENMATCH] <= 1'b0;
                if (rsr_r[7:1] == {`TW_TEN_PREFIX, adr_r[9:8]} &&
                    (!rsr_r[0] || prior_r)) begin
                  st_r[`TW_S_DIR] <= rsr_r[0];
                  st_r[`TW_S_DATA] <= 1'b0;
                  snx_r <= rsr_r[0] ? S_TXW : S_ADDR2;
                  if (rsr_r[0])
                    st_r[`TW_S_TENMATCH] <= 1'b1;
                  sst_r <= S_ACK;
                  ssda_r <= 1'b1;
                end
              end
            end
          end
          S_ACK: if (scl_fall) begin
            ssda_r <= 1'b0;
            irqst_r[`TW_I_SLV] <= 1'b1;
            sst_r <= snx_r;
            if (snx_r == S_TXW && !st_r[`TW_S_TXFULL])
              ctl_r[`TW_C_CLKREL] <= 1'b0;
            if (snx_r == S_RX && ctl_r[`TW_C_RXSTR] &&
                st_r[`TW_S_RXFULL])
              ctl_r[`TW_C_CLKREL] <= 1'b0;
          end
          S_TXW: if (ctl_r[`TW_C_CLKREL]) begin
            ssda_r <= ~txb_r[7];
            tsh_r <= {txb_r[6:0], 1'b0};
            st_r[`TW_S_TXFULL] <= 1'b0;
            sbit_r <= 4'h0;
            sst_r <= S_TX;
          end
          S_TX: if (scl_fall) begin
            if (sbit_r == 4'd7) begin
              ssda_r <= 1'b0;
              sst_r <= S_TXA;
            end else begin
              ssda_r <= ~tsh_r[7];
              tsh_r <= {tsh_r[6:0], 1'b0};
              sbit_r <= sbit_r + 4'd1;
            end
          end
          S_TXA: begin
            if (scl_rise)
              st_r[`TW_S_ACKIN] <= sda_in;
            if (scl_fall) begin
              irqst_r[`TW_I_SLV] <= 1'b1;
              sst_r <= S_IDLE;
              if (!st_r[`TW_S_ACKIN]) begin
                sst_r <= S_TXW;
                if (!st_r[`TW_S_TXFULL])
                  ctl_r[`TW_C_CLKREL] <= 1'b0;
              end
            end
          end
          default: ;
        endcase
      end
      // transmit register load by software
      if (wr && paddr == `TW_OFF_TXB) begin
        if (st_r[`TW_S_TXFULL])
          st_r[`TW_S_WRCOLL] <= 1'b1;
        st_r[`TW_S_TXFULL] <= 1'b1;
      end
      // port disabled: release bus, park both sequencers
      if (!ctl_r[`TW_C_EN]) begin
        mst_r <= M_IDLE;
        sst_r <= S_IDLE;
        msda_r <= 1'b0;
        mscl_r <= 1'b0;
        ssda_r <= 1'b0;
        mown_r <= 1'b0;
      end
    end
  end
endmodule

// >>> dv/tw_port_properties.sv
/* checker for tw_port: apb answer, register widths, readback, pins.
   assumes bind to tw_port and the defines header on the include path. */
`timescale 1ns/1ps
`include "tw_defines.vh"
module tw_port_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe_n,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire irq
);
  wire rd = pready && psel && !pwrite;
  wire wr = pready && psel && pwrite;
  reg [8:0] baud_r;
  reg [9:0] addr_r;
  reg en_r;
  reg [3:0] off_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_r <= `TW_BAUD_RST;
      addr_r <= `TW_ADDR_RST;
      en_r <= 1'b0;
      off_r <= 4'h0;
    end else begin
      if (wr && paddr == `TW_OFF_BAUD) baud_r <= pwdata[8:0];
      if (wr && paddr == `TW_OFF_ADDR) addr_r <= pwdata[9:0];
      if (wr && paddr == `TW_OFF_CTL) en_r <= pwdata[`TW_C_EN];
      off_r <= en_r ? 4'h0 : off_r + {3'h0, off_r != 4'hF};
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (s_access |=> s_answer)
    else $error("apb answer not a one cycle pulse");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_unmapped_err: assert property (
    (rd || wr) |-> pslverr == (paddr > `TW_OFF_MASK || paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  a_rxbuf_width: assert property (
    rd && paddr == `TW_OFF_RXBUF |-> prdata[31:8] == 24'h0)
    else $error("receive buffer wider than a byte");
  a_txb_width: assert property (
    rd && paddr == `TW_OFF_TXB |-> prdata[31:8] == 24'h0)
    else $error("transmit byte wider than a byte");
  a_baud_back: assert property (
    rd && paddr == `TW_OFF_BAUD |-> prdata == {23'h0, baud_r})
    else $error("baud reload readback wrong");
  a_addr_back: assert property (
    rd && paddr == `TW_OFF_ADDR |-> prdata == {22'h0, addr_r})
    else $error("own address readback wrong");
  a_ctl_enable: assert property (
    rd && paddr == `TW_OFF_CTL |-> prdata[31:16] == 16'h0 && prdata[15] == en_r)
    else $error("control readback wrong");
  a_stat_width: assert property (
    rd && paddr == `TW_OFF_STAT |-> prdata[31:16] == 16'h0)
    else $error("status wider than sixteen bits");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("bus output level not low");
  a_parked_idle: assert property (
    off_r == 4'hF |-> scl_oe_n && sda_oe_n)
    else $error("disabled port holds a bus line");
endmodule
bind tw_port tw_port_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .irq(irq)
);

// >>> dv/tw_bus_master_model.sv
/* behavioural master on the shared two-wire bus, open drain.
   assumes pull-ups on the wires; honours clock stretching. */
`timescale 1ns/1ps
module tw_bus_master_model #(parameter int HALF = 10) (
  input wire pclk,
  input wire scl,
  input wire sda,
  output reg scl_rel,
  output reg sda_rel
);
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // release clock, wait out any stretch
  task automatic up();
    scl_rel <= 1'b1;
    @(posedge pclk);
    while (!scl) @(posedge pclk);
    wt(HALF);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_rel <= b;
    wt(HALF);
    up();
    s = sda;
    scl_rel <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic start();
    sda_rel <= 1'b1;
    wt(HALF);
    up();
    sda_rel <= 1'b0;
    wt(HALF);
    scl_rel <= 1'b0;
    wt(HALF);
  endtask
  task automatic stop();
    sda_rel <= 1'b0;
    wt(HALF);
    up();
    sda_rel <= 1'b1;
    wt(HALF);
  endtask
  task automatic put(input logic [7:0] v, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, nack);
  endtask
  task automatic get(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule

// >>> dv/tw_port_tb_top.sv
/* self-checking bench for tw_port: apb tasks, bus master model.
   assumes the defines header on the include path, checker bound. */
`timescale 1ns/1ps
`include "tw_defines.vh"
module tw_port_tb_top;
  reg pclk;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire scl_out;
  wire scl_oe_n;
  wire sda_out;
  wire sda_oe_n;
  wire irq;
  wire m_scl;
  wire m_sda;
  wire scl = (scl_oe_n | scl_out) & m_scl;
  wire sda = (sda_oe_n | sda_out) & m_sda;
  int err_count;
  int comparisons;
  int cyc;
  logic [31:0] q;
  logic [7:0] d;
  logic e;
  logic nk;
  tw_port i_tw_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq)
  );
  tw_bus_master_model i_tw_bus_master_model (
    .pclk(pclk), .scl(scl), .sda(sda), .scl_rel(m_scl), .sda_rel(m_sda)
  );
  task automatic conclude();
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd);
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk32(q & m, exp);
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`TW_OFF_CTL, 32'hFFFFFFFF, 32'h1000);
    rdchk(`TW_OFF_STAT, 32'hFFFFFFFF, 32'h0);
    wr(`TW_OFF_CTL, 32'h2FE0);
    rdchk(`TW_OFF_CTL, 32'hFFFFFFFF, 32'h2FE0);
    wr(`TW_OFF_STAT, 32'hFFFF);
    rdchk(`TW_OFF_STAT, 32'hFFFFFFFF, 32'hFFC0);
    wr(`TW_OFF_STAT, 32'h0);
    wr(`TW_OFF_BAUD, 32'hFFFF);
    rdchk(`TW_OFF_BAUD, 32'hFFFFFFFF, 32'h1FF);
    rdchk(8'h20, 32'hFFFFFFFF, 32'h0);
    chk1(e, 1'b1);
    wr(`TW_OFF_BAUD, 32'h4);
    wr(`TW_OFF_MASK, 32'h7);
    wr(`TW_OFF_ADDR, 32'h52);
    wr(`TW_OFF_CTL, 32'h9000);
    i_tw_bus_master_model.start();
    i_tw_bus_master_model.put(8'hA4, nk);
    chk1(nk, 1'b0);
    repeat (4) @(posedge pclk);
    chk1(irq, 1'b1);
    rdchk(`TW_OFF_IRQ, 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
    i_tw_bus_master_model.put(8'h3C, nk);
    chk1(nk, 1'b0);
    i_tw_bus_master_model.put(8'hC3, nk);
    chk1(nk, 1'b1);
    rdchk(`TW_OFF_STAT, 32'h42, 32'h42);
    rdchk(`TW_OFF_IRQ, 32'h1, 32'h1);
    rdchk(`TW_OFF_RXBUF, 32'hFFFFFFFF, 32'h3C);
    rdchk(`TW_OFF_STAT, 32'h2, 32'h0);
    i_tw_bus_master_model.stop();
    i_tw_bus_master_model.start();
    i_tw_bus_master_model.put(8'hA6, nk);
    chk1(nk, 1'b1);
    i_tw_bus_master_model.stop();
    wr(`TW_OFF_STAT, 32'h0);
    wr(`TW_OFF_ADDR, 32'h2A5);
    wr(`TW_OFF_CTL, 32'h9400);
    i_tw_bus_master_model.start();
    i_tw_bus_master_model.put(8'hF4, nk);
    chk1(nk, 1'b0);
    i_tw_bus_master_model.put(8'hA5, nk);
    chk1(nk, 1'b0);
    rdchk(`TW_OFF_STAT, 32'h100, 32'h100);
    i_tw_bus_master_model.start();
    i_tw_bus_master_model.put(8'hF5, nk);
    chk1(nk, 1'b0);
    fork
      i_tw_bus_master_model.get(1'b1, d);
      begin
        repeat (60) @(posedge pclk);
        chk1(scl, 1'b0);
        rdchk(`TW_OFF_CTL, 32'h1000, 32'h0);
        wr(`TW_OFF_TXB, 32'h96);
        rdchk(`TW_OFF_STAT, 32'h1, 32'h1);
        wr(`TW_OFF_CTL, 32'h9400);
      end
    join
    chk32({24'h0, d}, 32'h96);
    i_tw_bus_master_model.stop();
    wr(`TW_OFF_CTL, 32'h9000);
    wr(`TW_OFF_MASK, 32'h0);
    i_tw_bus_master_model.start();
    wr(`TW_OFF_CTL, 32'h9001);
    repeat (8) @(posedge pclk);
    chk1(irq, 1'b0);
    wr(`TW_OFF_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b1);
    rdchk(`TW_OFF_STAT, 32'h400, 32'h400);
    rdchk(`TW_OFF_IRQ, 32'h4, 32'h4);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
    i_tw_bus_master_model.stop();
    wr(`TW_OFF_CTL, 32'h9001);
    repeat (20) @(posedge pclk);
    chk1(sda, 1'b0);
    chk1(scl, 1'b0);
    wr(`TW_OFF_CTL, 32'h9004);
    repeat (20) @(posedge pclk);
    chk1(scl, 1'b1);
    chk1(sda, 1'b1);
    rdchk(`TW_OFF_IRQ, 32'h2, 32'h2);
    conclude();
  end
endmodule
